// ---- fsc_regs.vh ----
// Constants for the fieldbus slave state control block.
// Assumes inclusion by fsc_state_ctrl.v, the checker and the testbench.
`ifndef FSC_REGS_VH
`define FSC_REGS_VH
// State codes
`define FSC_ST_INIT 4'h1
`define FSC_ST_PREOP 4'h2
`define FSC_ST_BOOT 4'h3
`define FSC_ST_SAFEOP 4'h4
`define FSC_ST_OP 4'h8
// Frame check
`define FSC_CRC_INIT 32'hFFFF_FFFF
`define FSC_CRC_POLY 32'hEDB8_8320
`define FSC_CRC_RESIDUE 32'hDEBB_20E3
// Process data per frame, bytes
`define FSC_PD_MAX_BYTES 11'h5CE
// Local time step per clock, ns
`define FSC_CLK_PERIOD_NS 8
`define FSC_TIME_STEP 64'h0000_0000_0000_0008
`endif

// ---- fsc_state_ctrl.v ----
// Slave-side state control, frame check, segment error counts, logical mapping.
// Assumes one 125 MHz clock; master commands and frame bytes arrive on i_clk.
`timescale 1ns/1ns
`default_nettype none
`include "fsc_regs.vh"

module fsc_state_ctrl
#(
   parameter NSEG = 4,
   parameter SEGW = 2,
   parameter CNTW = 8
)
(
   // Clock and reset
   input wire i_clk,
   input wire i_reset,
   // State request from master
   input wire i_req_valid,
   input wire [3:0] i_req_state,
   input wire i_mbx_cfg_ok,
   input wire i_pd_cfg_ok,
   input wire i_out_data_valid,
   // Frame byte stream
   input wire i_rx_valid,
   input wire i_rx_sof,
   input wire i_rx_eof,
   input wire [7:0] i_rx_data,
   input wire [SEGW-1:0] i_rx_seg,
   input wire i_rx_udp,
   input wire i_first_station,
   // Sub-telegram
   input wire i_sub_valid,
   input wire i_sub_write,
   input wire [31:0] i_sub_laddr,
   input wire [10:0] i_sub_len,
   input wire [31:0] i_map_start,
   input wire [31:0] i_map_len,
   // Counter readout
   input wire [SEGW-1:0] i_cnt_sel,
   input wire i_cnt_clear,
   // Measurement strobe pin
   input wire i_meas_pin,
   // State outputs
   output reg [3:0] o_state,
   output reg o_req_reject,
   output reg o_mbx_enable,
   output reg o_foe_only,
   output reg o_pd_in_enable,
   output reg o_pd_out_enable,
   output reg o_outputs_safe,
   output reg o_copy_inputs,
   // Frame results
   output reg o_crc_ok,
   output reg o_crc_err,
   output reg o_strip_udp,
   output reg [CNTW-1:0] o_cnt_value,
   // Sub-telegram results
   output reg o_sub_hit,
   output reg o_sub_denied,
   output reg o_sub_too_long,
   output reg [31:0] o_sub_offset,
   // Time stamp
   output reg [63:0] o_local_time,
   output reg [63:0] o_meas_time,
   output reg o_meas_valid
);

   // ==========================================================
   // Functions
   // ==========================================================
   function [31:0] crc_byte;
      input [31:0] c;
      input [7:0] d;
      integer k;
      reg [31:0] r;
      begin
         r = c ^ {24'h00_0000, d};
         for (k = 0; k < 8; k = k + 1)
         begin
            r = r[0] ? ((r >> 1) ^ `FSC_CRC_POLY) : (r >> 1);
         end
         crc_byte = r;
      end
   endfunction

   function legal_step;
      input [3:0] cur;
      input [3:0] req;
      begin
         case (cur)
            `FSC_ST_INIT:
               legal_step = (req == `FSC_ST_PREOP) || (req == `FSC_ST_BOOT);
            `FSC_ST_PREOP:
               legal_step = (req == `FSC_ST_INIT) || (req == `FSC_ST_SAFEOP);
            `FSC_ST_SAFEOP:
               legal_step = (req == `FSC_ST_INIT) || (req == `FSC_ST_PREOP)
                  || (req == `FSC_ST_OP);
            `FSC_ST_OP:
               legal_step = (req == `FSC_ST_INIT) || (req == `FSC_ST_PREOP)
                  || (req == `FSC_ST_SAFEOP);
            `FSC_ST_BOOT:
               legal_step = (req == `FSC_ST_INIT);
            default:
               legal_step = 1'b0;
         endcase
      end
   endfunction

   // ==========================================================
   // Slave state machine
   // ==========================================================
   reg [3:0] state_reg;
   reg [3:0] state_next;
   reg reject_next;
   reg guard_ok;

   always @*
   begin
      state_next = state_reg;
      reject_next = 1'b0;
      guard_ok = 1'b1;
      case (i_req_state)
         `FSC_ST_PREOP:
            guard_ok = (state_reg != `FSC_ST_INIT) || i_mbx_cfg_ok;
         `FSC_ST_SAFEOP:
            guard_ok = (state_reg != `FSC_ST_PREOP) || i_pd_cfg_ok;
         `FSC_ST_OP:
            guard_ok = i_out_data_valid;
         default:
            guard_ok = 1'b1;
      endcase
      if (i_req_valid && (i_req_state != state_reg))
      begin
         if (legal_step(state_reg, i_req_state) && guard_ok)
            state_next = i_req_state;
         else
            reject_next = 1'b1;
      end
   end

   always @(posedge i_clk)
   begin
      if (i_reset)
      begin
         state_reg <= `FSC_ST_INIT;
         o_state <= `FSC_ST_INIT;
         o_req_reject <= 1'b0;
         o_mbx_enable <= 1'b0;
         o_foe_only <= 1'b0;
         o_pd_in_enable <= 1'b0;
         o_pd_out_enable <= 1'b0;
         o_outputs_safe <= 1'b1;
         o_copy_inputs <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         o_state <= state_next;
         o_req_reject <= reject_next;
         // Mailbox in every state but Init; Boot limited to file access
         o_mbx_enable <= (state_next != `FSC_ST_INIT);
         o_foe_only <= (state_next == `FSC_ST_BOOT);
         o_pd_in_enable <= (state_next == `FSC_ST_SAFEOP)
            || (state_next == `FSC_ST_OP);
         o_pd_out_enable <= (state_next == `FSC_ST_OP);
         o_outputs_safe <= (state_next != `FSC_ST_OP);
         // Inputs copied in the same cycle SafeOp is first reported after PreOp
         o_copy_inputs <= (state_next == `FSC_ST_SAFEOP)
            && (state_reg == `FSC_ST_PREOP);
      end
   end

   // ==========================================================
   // Frame check and segment error counters
   // ==========================================================
   reg [31:0] crc_reg;
   reg [31:0] crc_next;
   reg [SEGW-1:0] seg_reg;
   reg [CNTW-1:0] err_cnt [0:NSEG-1];
   wire frame_bad;
   integer s;

   always @*
   begin
      crc_next = crc_reg;
      if (i_rx_valid)
      begin
         if (i_rx_sof)
            crc_next = crc_byte(`FSC_CRC_INIT, i_rx_data);
         else
            crc_next = crc_byte(crc_reg, i_rx_data);
      end
   end

   // FCS bytes included, so a clean frame leaves the fixed residue
   assign frame_bad = (crc_next != `FSC_CRC_RESIDUE);

   always @(posedge i_clk)
   begin
      if (i_reset)
      begin
         crc_reg <= `FSC_CRC_INIT;
         seg_reg <= {SEGW{1'b0}};
         o_crc_ok <= 1'b0;
         o_crc_err <= 1'b0;
         o_strip_udp <= 1'b0;
         o_cnt_value <= {CNTW{1'b0}};
         for (s = 0; s < NSEG; s = s + 1)
            err_cnt[s] <= {CNTW{1'b0}};
      end
      else
      begin
         crc_reg <= crc_next;
         if (i_rx_valid && i_rx_sof)
         begin
            seg_reg <= i_rx_seg;
            // Downstream stations see the bare frame
            o_strip_udp <= i_rx_udp && i_first_station;
         end
         o_crc_ok <= i_rx_valid && i_rx_eof && !frame_bad;
         o_crc_err <= i_rx_valid && i_rx_eof && frame_bad;
         // Counting wins over a clear in the same cycle
         for (s = 0; s < NSEG; s = s + 1)
         begin
            if (i_rx_valid && i_rx_eof && frame_bad
               && (s == (i_rx_sof ? i_rx_seg : seg_reg)))
            begin
               if (err_cnt[s] != {CNTW{1'b1}})
                  err_cnt[s] <= err_cnt[s] + 1'b1;
            end
            else if (i_cnt_clear && (s == i_cnt_sel))
               err_cnt[s] <= {CNTW{1'b0}};
         end
         o_cnt_value <= err_cnt[i_cnt_sel];
      end
   end

   // ==========================================================
   // Logical mapping of sub-telegrams
   // ==========================================================
   // 33-bit sums keep the 4 GB window from wrapping
   wire [32:0] sub_end;
   wire [32:0] map_end;
   wire sub_inside;
   wire sub_allowed;
   wire [10:0] pd_sum;
   reg [10:0] pd_total_reg;

   assign sub_end = {1'b0, i_sub_laddr} + {22'h00_0000, i_sub_len};
   assign map_end = {1'b0, i_map_start} + {1'b0, i_map_len};
   assign sub_inside = (i_sub_laddr >= i_map_start)
      && (sub_end <= map_end);
   assign sub_allowed = i_sub_write ? o_pd_out_enable : o_pd_in_enable;
   assign pd_sum = pd_total_reg + i_sub_len;

   always @(posedge i_clk)
   begin
      if (i_reset)
      begin
         pd_total_reg <= 11'h000;
         o_sub_hit <= 1'b0;
         o_sub_denied <= 1'b0;
         o_sub_too_long <= 1'b0;
         o_sub_offset <= 32'h0000_0000;
      end
      else
      begin
         if (i_rx_valid && i_rx_sof)
            pd_total_reg <= 11'h000;
         else if (i_sub_valid)
            pd_total_reg <= pd_sum;
         // Overflow of the running total also flags too long
         o_sub_too_long <= i_sub_valid
            && ((pd_sum > `FSC_PD_MAX_BYTES) || (pd_sum < pd_total_reg));
         o_sub_hit <= i_sub_valid && sub_inside && sub_allowed;
         o_sub_denied <= i_sub_valid && sub_inside && !sub_allowed;
         o_sub_offset <= i_sub_laddr - i_map_start;
      end
   end

   // ==========================================================
   // Local time and measurement stamp
   // ==========================================================
   reg meas_s1_reg;
   reg meas_s2_reg;
   reg meas_s3_reg;

   always @(posedge i_clk)
   begin
      if (i_reset)
      begin
         meas_s1_reg <= 1'b0;
         meas_s2_reg <= 1'b0;
         meas_s3_reg <= 1'b0;
         o_local_time <= 64'h0000_0000_0000_0000;
         o_meas_time <= 64'h0000_0000_0000_0000;
         o_meas_valid <= 1'b0;
      end
      else
      begin
         meas_s1_reg <= i_meas_pin;
         meas_s2_reg <= meas_s1_reg;
         meas_s3_reg <= meas_s2_reg;
         // 8 ns step beats the 10 ns target; sync delay is fixed, not jitter
         o_local_time <= o_local_time + `FSC_TIME_STEP;
         o_meas_valid <= meas_s2_reg && !meas_s3_reg;
         if (meas_s2_reg && !meas_s3_reg)
            o_meas_time <= o_local_time;
      end
   end

endmodule // fsc_state_ctrl
`default_nettype wire

// ---- fsc_checker.sv ----
// Checker: state machine outputs against master requests.
// Assumes a bind onto fsc_state_ctrl, one clock, sync reset.
`timescale 1ns/1ns
`default_nettype none
`include "fsc_regs.vh"
module fsc_checker
(
   // Clock, reset, request
   input wire logic i_clk,
   input wire logic i_reset,
   input wire logic i_req_valid,
   input wire logic [3:0] i_req_state,
   // Observed outputs
   input wire logic [3:0] o_state,
   input wire logic o_req_reject,
   input wire logic o_mbx_enable,
   input wire logic o_foe_only,
   input wire logic o_pd_in_enable,
   input wire logic o_pd_out_enable,
   input wire logic o_outputs_safe,
   input wire logic o_copy_inputs
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_reset);
   // =======================================
   // Requests
   sequence s_req;
      i_req_valid && i_req_state != o_state;
   endsequence
   a_req_answer: assert property (s_req |=> o_req_reject || o_state == $past(i_req_state))
      else $error("request unanswered");
   a_reject_keeps_state: assert property (o_req_reject |-> o_state == $past(o_state))
      else $error("state moved on reject");
   a_boot_from_init: assert property (o_state == `FSC_ST_BOOT && $past(o_state) != o_state
      |-> $past(o_state) == `FSC_ST_INIT)
      else $error("boot entered from wrong state");
   a_copy_on_safeop: assert property (o_copy_inputs
      |-> o_state == `FSC_ST_SAFEOP && $past(o_state) == `FSC_ST_PREOP)
      else $error("input copy out of place");
   // =======================================
   // Functions per state
   a_init_quiet: assert property (o_state == `FSC_ST_INIT
      |-> !o_mbx_enable && !o_pd_in_enable && !o_pd_out_enable)
      else $error("traffic in init");
   a_safeop_safe: assert property (o_state == `FSC_ST_SAFEOP
      |-> o_pd_in_enable && o_outputs_safe && !o_pd_out_enable)
      else $error("safeop outputs wrong");
   a_op_outputs: assert property (o_state == `FSC_ST_OP |-> o_pd_out_enable && !o_outputs_safe)
      else $error("op outputs wrong");
   a_boot_foe_only: assert property (o_state == `FSC_ST_BOOT |-> o_foe_only && !o_pd_in_enable)
      else $error("boot traffic wrong");
endmodule // fsc_checker
bind fsc_state_ctrl fsc_checker i_chk (.i_clk, .i_reset, .i_req_valid, .i_req_state, .o_state,
   .o_req_reject, .o_mbx_enable, .o_foe_only, .o_pd_in_enable, .o_pd_out_enable,
   .o_outputs_safe, .o_copy_inputs);
`default_nettype wire

// ---- fsc_master_model.sv ----
// Master model: state requests and set-up levels.
// Assumes the bench calls its tasks; drives after falling edges.
`timescale 1ns/1ns
`default_nettype none
module fsc_master_model
(
   // Clock
   input wire logic i_clk,
   // Request and set-up levels
   output logic o_req_valid,
   output logic [3:0] o_req_state,
   output logic [2:0] o_setup
);
   initial
   begin
      o_req_valid = 1'b0;
      o_req_state = 4'h1;
      o_setup = 3'h0;
   end
   // One-cycle pulse; only commands move the slave
   task automatic request(input logic [3:0] st);
      @(negedge i_clk);
      o_req_valid = 1'b1;
      o_req_state = st;
      @(negedge i_clk);
      o_req_valid = 1'b0;
   endtask
   // Mailbox channels, process data from channel 2, output data
   task automatic setup(input logic [2:0] lv);
      o_setup = lv;
   endtask
endmodule // fsc_master_model
`default_nettype wire

// ---- tb_top.sv ----
// Testbench: state walk, refusals, frame check, mapping.
// Assumes the design answers one cycle after each request.
`timescale 1ns/1ns
`default_nettype none
`include "fsc_regs.vh"
module tb_top;
   logic clk = 1'b0, rst = 1'b1, rv = 1'b0, sof = 1'b0, eof = 1'b0, udp = 1'b0, fst = 1'b0;
   logic sv = 1'b0, sw = 1'b0, clr = 1'b0, mp = 1'b0, rqv;
   logic [10:0] sl = 11'h000;
   logic [63:0] lt, mt;
   logic [7:0] rd = 8'h00;
   logic [1:0] seg = 2'h0;
   logic [31:0] la = 32'h0000_0000, off;
   logic [3:0] rqs, st;
   logic [2:0] su;
   logic rej, mbx, foe, pdin, pdout, safe, copy, cok, cerr, strip, hit, den, tlong, mv;
   logic [7:0] cnt;
   int fails = 0, tests_run = 0;
   always #4 clk = ~clk;
   fsc_master_model i_mst (.i_clk(clk), .o_req_valid(rqv), .o_req_state(rqs), .o_setup(su));
   fsc_state_ctrl i_dut (.i_clk(clk), .i_reset(rst), .i_req_valid(rqv), .i_req_state(rqs),
      .i_mbx_cfg_ok(su[2]), .i_pd_cfg_ok(su[1]), .i_out_data_valid(su[0]), .i_rx_valid(rv),
      .i_rx_sof(sof), .i_rx_eof(eof), .i_rx_data(rd), .i_rx_seg(seg), .i_rx_udp(udp),
      .i_first_station(fst), .i_sub_valid(sv), .i_sub_write(sw), .i_sub_laddr(la),
      .i_sub_len(sl), .i_map_start(32'h0000_1000), .i_map_len(32'h0000_0100),
      .i_cnt_sel(seg), .i_cnt_clear(clr), .i_meas_pin(mp), .o_state(st),
      .o_req_reject(rej), .o_mbx_enable(mbx), .o_foe_only(foe), .o_pd_in_enable(pdin),
      .o_pd_out_enable(pdout), .o_outputs_safe(safe), .o_copy_inputs(copy), .o_crc_ok(cok),
      .o_crc_err(cerr), .o_strip_udp(strip), .o_cnt_value(cnt), .o_sub_hit(hit),
      .o_sub_denied(den), .o_sub_too_long(tlong), .o_sub_offset(off), .o_local_time(lt),
      .o_meas_time(mt), .o_meas_valid(mv));
   // =======================================
   // Helpers
   task automatic finish_test();
      $display("fails=%0d tests_run=%0d", fails, tests_run);
      if (fails == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] crc8(input logic [31:0] c, input logic [7:0] d);
      for (int k = 0; k < 8; k++)
         c = (c >> 1) ^ ((c[0] ^ d[k]) ? `FSC_CRC_POLY : 32'h0000_0000);
      return c;
   endfunction
   task automatic go(input logic [3:0] rq, input logic [3:0] exp, input logic r);
      i_mst.request(rq);
      chk(st, exp);
      chk(rej, r);
   endtask
   // =======================================
   // Scenarios
   task automatic walk_up();
      go(`FSC_ST_PREOP, `FSC_ST_INIT, 1'b1);
      i_mst.setup(3'b100);
      go(`FSC_ST_PREOP, `FSC_ST_PREOP, 1'b0);
      chk({mbx, pdin}, 2'b10);
      i_mst.setup(3'b110);
      go(`FSC_ST_SAFEOP, `FSC_ST_SAFEOP, 1'b0);
      chk({copy, safe, pdin}, 3'b111);
      go(`FSC_ST_OP, `FSC_ST_SAFEOP, 1'b1);
      i_mst.setup(3'b111);
      go(`FSC_ST_OP, `FSC_ST_OP, 1'b0);
      chk({pdout, safe}, 2'b10);
   endtask
   // One descriptor; judged as {hit, denied, too long} one cycle later
   task automatic sub(input logic w, input logic [31:0] a, input logic [10:0] n,
      input logic [2:0] exp);
      @(negedge clk);
      {sv, sw, la, sl} = {1'b1, w, a, n};
      @(negedge clk);
      sv = 1'b0;
      chk({hit, den, tlong}, exp);
   endtask
   // Running total hits 1486 exactly, then one byte more
   task automatic sub_access();
      sub(1'b1, 32'h0000_1010, 11'h004, 3'b100);
      chk(off, 32'h0000_0010);
      sub(1'b0, 32'h0000_2000, 11'h5CA, 3'b000);
      sub(1'b1, 32'h0000_10FF, 11'h001, 3'b101);
      chk(off, 32'h0000_00FF);
   endtask
   task automatic clear_cnt();
      @(negedge clk);
      clr = 1'b1;
      @(negedge clk);
      clr = 1'b0;
      @(negedge clk);
      chk(cnt, 8'h00);
   endtask
   // Two sync stages put the stamp two time steps after the pin edge
   task automatic measure();
      logic [63:0] t0;
      @(negedge clk);
      t0 = lt;
      mp = 1'b1;
      @(negedge clk);
      chk(lt[31:0] - t0[31:0], 32'h0000_0008);
      repeat (2) @(negedge clk);
      chk(mv, 1'b1);
      chk(mt[31:0], t0[31:0] + 32'h0000_0010);
      @(negedge clk);
      mp = 1'b0;
      chk(mv, 1'b0);
   endtask
   // Bad frame flips one data bit; counter of its segment must rise
   task automatic frame(input logic bad, input logic first, input logic [7:0] exp_cnt);
      logic [7:0] f [7];
      logic [31:0] c;
      c = `FSC_CRC_INIT;
      fst = first;
      for (int i = 0; i < 3; i++)
      begin
         f[i] = 8'(i + 1);
         c = crc8(c, f[i]);
      end
      for (int i = 0; i < 4; i++)
         f[3 + i] = 8'(~c >> (8 * i));
      f[1][0] = f[1][0] ^ bad;
      for (int i = 0; i < 7; i++)
      begin
         @(negedge clk);
         {rv, sof, eof, rd, udp, seg} = {1'b1, i == 0, i == 6, f[i], 1'b1, 2'h2};
      end
      @(negedge clk);
      {rv, eof} = 2'b00;
      chk({cok, cerr}, {~bad, bad});
      chk(strip, first);
      @(negedge clk);
      chk(cnt, exp_cnt);
   endtask
   task automatic illegal();
      go(`FSC_ST_BOOT, `FSC_ST_OP, 1'b1);
      go(4'h5, `FSC_ST_OP, 1'b1);
      go(`FSC_ST_INIT, `FSC_ST_INIT, 1'b0);
      chk(mbx, 1'b0);
      sub(1'b1, 32'h0000_1000, 11'h004, 3'b010);
      go(`FSC_ST_BOOT, `FSC_ST_BOOT, 1'b0);
      chk(foe, 1'b1);
      sub(1'b0, 32'h0000_1000, 11'h004, 3'b010);
      go(`FSC_ST_PREOP, `FSC_ST_BOOT, 1'b1);
   endtask
   // =======================================
   // Main sequence and hang guard
   initial
   begin
      repeat (12) @(negedge clk);
      chk({st, safe}, {`FSC_ST_INIT, 1'b1});
      rst = 1'b0;
      walk_up();
      sub_access();
      frame(1'b0, 1'b1, 8'h00);
      frame(1'b1, 1'b0, 8'h01);
      clear_cnt();
      measure();
      illegal();
      finish_test();
   end
   initial
   begin
      repeat (5000) @(posedge clk);
      fails++;
      finish_test();
   end
endmodule // tb_top
`default_nettype wire
